// ===== include/xmb_consts.svh
// constants for the external memory bus pin block
`ifndef XMB_CONSTS_SVH
`define XMB_CONSTS_SVH

`define XMB_ADDR_W       24
`define XMB_DATA_W       8
`define XMB_NUM_CS       4
`define XMB_ADDR_RST     24'h000000
`define XMB_DATA_RST     8'h00
`define XMB_CS0_BASE     24'h000000
`define XMB_CS0_MASK     24'hF80000
`define XMB_CS1_BASE     24'h080000
`define XMB_CS1_MASK     24'hF80000
`define XMB_CS2_BASE     24'h100000
`define XMB_CS2_MASK     24'hF80000
`define XMB_CS3_BASE     24'h000080
`define XMB_CS3_MASK     24'hFFFF80
`define XMB_CS3_IO       1'b1

`endif

// ===== include/xmb_pkg.sv
// types for the external memory bus pin block
package xmb_pkg;
    typedef enum logic [1:0] {
        XMB_SPACE_MEM,
        XMB_SPACE_IO,
        XMB_SPACE_FETCH,
        XMB_SPACE_RSVD
    } xmb_space_t;

    typedef enum logic [2:0] {
        XMB_ST_IDLE,
        XMB_ST_SETUP,
        XMB_ST_STROBE,
        XMB_ST_FLOAT,
        XMB_ST_GRANT
    } xmb_state_t;
endpackage

// ===== design/xmb_csgen.sv
// chip-select decoder fed from the address lines
`timescale 1ns/100ps
`default_nettype none
`include "xmb_consts.svh"

module xmb_csgen #(
    parameter int ADDR_W = `XMB_ADDR_W,
    parameter int NUM_CS = `XMB_NUM_CS
) (
    // decode source
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              is_io,
    input  wire logic              active,
    // decode result, one bit per select, active high
    output logic      [NUM_CS-1:0] hit
);
    // ranges fixed here; a programmable decoder would replace these tables
    localparam logic [`XMB_NUM_CS*`XMB_ADDR_W-1:0] BASES = {
        `XMB_CS3_BASE, `XMB_CS2_BASE, `XMB_CS1_BASE, `XMB_CS0_BASE};
    localparam logic [`XMB_NUM_CS*`XMB_ADDR_W-1:0] MASKS = {
        `XMB_CS3_MASK, `XMB_CS2_MASK, `XMB_CS1_MASK, `XMB_CS0_MASK};
    localparam logic [`XMB_NUM_CS-1:0] IO_SEL = {`XMB_CS3_IO, 3'h0};

    genvar i;
    generate
        for (i = 0; i < NUM_CS; i++) begin : g_cs
            assign hit[i] = active && (is_io == IO_SEL[i]) &&
                ((addr & MASKS[i*ADDR_W +: ADDR_W]) ==
                 BASES[i*ADDR_W +: ADDR_W]);
        end
    endgenerate
endmodule // xmb_csgen
`default_nettype wire

// ===== design/xmb_pins.sv
// external memory and I/O bus pin controller, bus master side
`timescale 1ns/100ps
`default_nettype none
`include "xmb_consts.svh"

module xmb_pins
    import xmb_pkg::*;
#(
    parameter int ADDR_W = `XMB_ADDR_W,
    parameter int DATA_W = `XMB_DATA_W
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              arst_n,
    // core access request
    input  wire logic              acc_req,
    input  wire logic              acc_write,
    input  wire xmb_pkg::xmb_space_t acc_space,
    input  wire logic [ADDR_W-1:0] acc_addr,
    input  wire logic [DATA_W-1:0] acc_wdata,
    output logic                   acc_ready,
    output logic                   acc_done,
    output logic      [DATA_W-1:0] acc_rdata,
    output logic                   bus_granted,
    // address pins
    input  wire logic [ADDR_W-1:0] addr_in,
    output logic      [ADDR_W-1:0] addr_out,
    output logic                   addr_oe,
    // data pins
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   data_oe,
    // request pins
    input  wire logic              io_space_request_n_in,
    output logic                   io_space_request_n,
    output logic                   io_space_request_oe,
    input  wire logic              memory_space_request_n_in,
    output logic                   memory_space_request_n,
    output logic                   memory_space_request_oe,
    // strobes
    output logic                   read_strobe_n,
    output logic                   write_strobe_n,
    output logic                   strobe_oe,
    output logic                   opcode_fetch_flag_n,
    output logic                   opcode_fetch_flag_oe,
    // chip selects
    output logic                   select_out_first,
    output logic                   select_out_second,
    output logic                   select_out_third,
    output logic                   select_out_fourth,
    // arbitration and wait
    input  wire logic              bus_release_request_n,
    output logic                   bus_release_grant_n,
    input  wire logic              wait_request_n
);
    import xmb_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic       bus_release_request_n_s1_r, bus_release_request_n_s2_r;
    logic       wait_s1_r, wait_s2_r;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bus_release_request_n_s1_r <= 1'b1;
            bus_release_request_n_s2_r <= 1'b1;
            wait_s1_r   <= 1'b1;
            wait_s2_r   <= 1'b1;
        end else begin
            bus_release_request_n_s1_r <= bus_release_request_n;
            bus_release_request_n_s2_r <= bus_release_request_n_s1_r;
            wait_s1_r   <= wait_request_n;
            wait_s2_r   <= wait_s1_r;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    xmb_state_t          state_r, state_nxt;
    logic [ADDR_W-1:0]   addr_r;
    logic [DATA_W-1:0]   wdata_r;
    logic                write_r;
    xmb_space_t          space_r;
    logic                out_en_r;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            XMB_ST_IDLE: begin
                if (!bus_release_request_n_s2_r)
                    state_nxt = XMB_ST_FLOAT;
                else if (acc_req)
                    state_nxt = XMB_ST_SETUP;
            end
            XMB_ST_SETUP:  state_nxt = XMB_ST_STROBE;
            XMB_ST_STROBE: begin
                if (wait_s2_r)
                    state_nxt = XMB_ST_IDLE;
            end
            XMB_ST_FLOAT:  state_nxt = bus_release_request_n_s2_r ? XMB_ST_IDLE
                                                   : XMB_ST_GRANT;
            XMB_ST_GRANT: begin
                if (bus_release_request_n_s2_r)
                    state_nxt = XMB_ST_IDLE;
            end
            default:       state_nxt = XMB_ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            state_r <= XMB_ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // access latched at acceptance so pins hold steady through the cycle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            addr_r  <= `XMB_ADDR_RST;
            wdata_r <= `XMB_DATA_RST;
            write_r <= 1'b0;
            space_r <= XMB_SPACE_MEM;
        end else if (state_r == XMB_ST_IDLE && state_nxt == XMB_ST_SETUP) begin
            addr_r  <= acc_addr;
            wdata_r <= acc_wdata;
            write_r <= acc_write;
            // reserved space folds to memory so only one request fires
            space_r <= (acc_space == XMB_SPACE_RSVD) ? XMB_SPACE_MEM
                                                     : acc_space;
        end
    end

    // drivers stay off through reset and come on one edge after release
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            out_en_r <= 1'b0;
        else
            out_en_r <= (state_nxt != XMB_ST_FLOAT) &&
                        (state_nxt != XMB_ST_GRANT);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            acc_rdata <= `XMB_DATA_RST;
        else if (state_r == XMB_ST_STROBE && wait_s2_r && !write_r)
            acc_rdata <= data_in;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            acc_done <= 1'b0;
        else
            acc_done <= (state_r == XMB_ST_STROBE) && wait_s2_r;
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    logic in_cycle;
    logic is_io;
    logic is_read;
    logic is_write;
    logic granted;
    logic [ADDR_W-1:0] dec_addr;
    logic              dec_io;
    logic              dec_active;
    logic [3:0]        cs_hit;

    assign in_cycle = (state_r == XMB_ST_SETUP) ||
                      (state_r == XMB_ST_STROBE);
    assign is_io    = (space_r == XMB_SPACE_IO);
    assign is_read  = (state_r == XMB_ST_STROBE) && !write_r;
    assign is_write = (state_r == XMB_ST_STROBE) && write_r;
    assign granted  = (state_r == XMB_ST_GRANT);

    assign acc_ready   = (state_r == XMB_ST_IDLE) && bus_release_request_n_s2_r;
    assign bus_granted = granted;

    assign addr_out = addr_r;
    assign addr_oe  = out_en_r;

    assign data_out = wdata_r;
    assign data_oe  = out_en_r && in_cycle && write_r;

    assign io_space_request_n      = !(in_cycle && is_io);
    assign memory_space_request_n  = !(in_cycle && !is_io);
    assign io_space_request_oe     = out_en_r;
    assign memory_space_request_oe = out_en_r;

    assign read_strobe_n  = !is_read;
    assign write_strobe_n = !is_write;
    assign strobe_oe      = out_en_r;

    assign opcode_fetch_flag_n  = !(in_cycle &&
                                    space_r == XMB_SPACE_FETCH);
    assign opcode_fetch_flag_oe = out_en_r;

    assign bus_release_grant_n = !granted;

    // ------------------------------------------------------------
    // chip selects: own cycles decode our address, granted cycles
    // decode the outside master's address and request lines
    // ------------------------------------------------------------
    assign dec_addr   = granted ? addr_in : addr_r;
    assign dec_io     = granted ? !io_space_request_n_in : is_io;
    assign dec_active = granted ? (!io_space_request_n_in ||
                                   !memory_space_request_n_in)
                                : in_cycle;

    xmb_csgen #(
        .ADDR_W (ADDR_W),
        .NUM_CS (`XMB_NUM_CS)
    ) u_csgen (
        .addr   (dec_addr),
        .is_io  (dec_io),
        .active (dec_active),
        .hit    (cs_hit)
    );

    assign select_out_first  = !cs_hit[0];
    assign select_out_second = !cs_hit[1];
    assign select_out_third  = !cs_hit[2];
    assign select_out_fourth = !cs_hit[3];

endmodule // xmb_pins
`default_nettype wire

// ===== tb/xmb_pins_props.sv
// concurrent checks on the external memory bus pin block
`timescale 1ns/100ps
`default_nettype none
module xmb_pins_props (
    // clock, reset and core side
    input wire logic mclk, arst_n, acc_req, acc_ready, acc_done,
    // pin side
    input wire logic addr_oe, data_oe, strobe_oe, opcode_fetch_flag_oe,
    input wire logic io_space_request_n, io_space_request_oe,
    input wire logic memory_space_request_n, memory_space_request_oe,
    input wire logic read_strobe_n, write_strobe_n, opcode_fetch_flag_n,
    input wire logic select_out_first, select_out_fourth, bus_release_grant_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    addr_float_a: assert property (!bus_release_grant_n |-> !addr_oe)
        else $error("address lines driven while released");
    data_write_a: assert property ($rose(data_oe) |=> !write_strobe_n)
        else $error("data driven outside a write");
    req_excl_a: assert property (addr_oe |-> io_space_request_n ||
        memory_space_request_n) else $error("both requests low");
    read_req_a: assert property (!read_strobe_n |-> !io_space_request_n ||
        !memory_space_request_n) else $error("read strobe without request");
    grant_float_a: assert property (!bus_release_grant_n |->
        !strobe_oe && !opcode_fetch_flag_oe && !io_space_request_oe)
        else $error("control lines driven while released");
    fetch_mem_a: assert property (!opcode_fetch_flag_n |->
        !memory_space_request_n) else $error("fetch flag without memory");
    done_time_a: assert property (acc_req && acc_ready |=>
        !acc_done [*2] ##[1:40] acc_done) else $error("access end misplaced");
    grant_after_a: assert property ($fell(bus_release_grant_n) |->
        !addr_oe && !$past(addr_oe)) else $error("grant before float");
    sel_space_a: assert property (addr_oe && !select_out_fourth |->
        !io_space_request_n) else $error("io select outside io space");
    reset_float_a: assert property (disable iff (1'b0)
        !arst_n |-> !io_space_request_oe && !memory_space_request_oe)
        else $error("requests driven in reset");
    cover property (acc_req && acc_ready && !write_strobe_n);
    cover property (!bus_release_grant_n);
    cover property (!opcode_fetch_flag_n);
endmodule // xmb_pins_props
bind xmb_pins xmb_pins_props u_props (.mclk, .arst_n, .acc_req, .acc_ready,
    .acc_done, .addr_oe, .data_oe, .strobe_oe, .opcode_fetch_flag_oe,
    .io_space_request_n, .io_space_request_oe, .memory_space_request_n,
    .memory_space_request_oe, .read_strobe_n, .write_strobe_n,
    .opcode_fetch_flag_n, .select_out_first, .select_out_fourth,
    .bus_release_grant_n);
`default_nettype wire

// ===== tb/xmb_mem_model.sv
// far-side memory with a programmable slow-device wait
`timescale 1ns/100ps
`default_nettype none
module xmb_mem_model (
    // bus pins as resolved on the board
    input  wire logic        mclk,
    input  wire logic [23:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        read_strobe_n,
    input  wire logic        write_strobe_n,
    // strobe cycles to hold the device off, 0 for a fast device
    input  wire logic [3:0]  waits,
    output logic      [7:0]  rdata,
    output logic             wait_request_n
);
    logic [7:0] mem [256];
    logic [7:0] last_r = 8'h00;
    logic [3:0] cnt_r = 4'h0;
    initial foreach (mem[i]) mem[i] = 8'h00;
    always @(posedge mclk) begin
        if (!write_strobe_n) mem[addr[7:0]] <= wdata;
        if (!read_strobe_n) last_r <= mem[addr[7:0]];
        cnt_r <= (read_strobe_n && write_strobe_n) ? 4'h0 : cnt_r + 4'h1;
    end
    // released data lines show the inverse of the last value, not a copy
    assign rdata = !read_strobe_n ? mem[addr[7:0]] : ~last_r;
    // held low from idle so the two-stage sync sees it before the strobe
    assign wait_request_n = (cnt_r >= waits);
endmodule // xmb_mem_model
`default_nettype wire

// ===== tb/test_xmb_pins.sv
// self-checking bench for the external memory bus pin block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    num_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_xmb_pins;
    import xmb_pkg::*;
    logic mclk = 1'b0, arst_n = 1'b0, acc_req = 1'b0, acc_write = 1'b0;
    xmb_space_t acc_space = XMB_SPACE_MEM;
    logic [23:0] acc_addr = 24'h000000, ext_addr = 24'h000000, addr_out;
    logic [7:0] acc_wdata = 8'h00, mdata, acc_rdata, data_out;
    logic ext_mem_n = 1'b1, bus_release_request_n = 1'b1;
    logic [3:0] waits = 4'h0;
    logic acc_ready, acc_done, bus_granted, addr_oe, data_oe, strobe_oe;
    logic io_space_request_n, io_space_request_oe, memory_space_request_n;
    logic memory_space_request_oe, read_strobe_n, write_strobe_n;
    logic opcode_fetch_flag_n, opcode_fetch_flag_oe, bus_release_grant_n;
    logic select_out_first, select_out_second, select_out_third;
    logic select_out_fourth, wait_request_n;
    int num_errors = 0, total_checks = 0;
    // --------------------------------------------------------------
    // board wiring: strobes and io request pulled up, released address and memory request show the master, released data shows the memory
    // --------------------------------------------------------------
    wire [23:0] addr_in = addr_oe ? addr_out : ext_addr;
    wire [7:0] data_in = data_oe ? data_out : mdata;
    wire memory_space_request_n_in =
        memory_space_request_oe ? memory_space_request_n : ext_mem_n;
    wire io_space_request_n_in = io_space_request_oe ? io_space_request_n : 1'b1;
    wire rd_pin = strobe_oe ? read_strobe_n : 1'b1;
    wire wr_pin = strobe_oe ? write_strobe_n : 1'b1;
    wire [5:0] oe_all = {addr_oe, data_oe | write_strobe_n, strobe_oe,
        opcode_fetch_flag_oe, memory_space_request_oe, io_space_request_oe};
    xmb_pins uut (.*);
    xmb_mem_model u_mem (.mclk(mclk), .addr(addr_in), .wdata(data_in),
        .read_strobe_n(rd_pin), .write_strobe_n(wr_pin), .waits(waits),
        .rdata(mdata), .wait_request_n(wait_request_n));
    always #20 mclk = ~mclk;
    function automatic logic [4:0] seen();
        return ~{opcode_fetch_flag_n, select_out_fourth, select_out_third,
                 select_out_second, select_out_first};
    endfunction
    task automatic acc(input xmb_space_t sp, input logic wr,
        input logic [23:0] a, input logic [7:0] d,
        output logic [4:0] s, output int lat);
        lat = 0;
        @(posedge mclk);
        acc_req <= 1'b1;
        acc_space <= sp;
        acc_write <= wr;
        acc_addr <= a;
        acc_wdata <= d;
        @(posedge mclk);
        acc_req <= 1'b0;
        #1 s = seen();
        do begin
            @(posedge mclk);
            #1 lat++;
            s |= seen();
        end while (acc_done !== 1'b1 && lat < 40);
    endtask
    task automatic t_reset();
        repeat (16) @(posedge mclk);
        #1 `CHK("oe in reset", 6'h10, oe_all)
        @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        #1 `CHK("oe after reset", 6'h3F, oe_all)
    endtask
    task automatic t_rw(input xmb_space_t sp, input logic [23:0] a,
        input logic [7:0] d, input logic [4:0] es);
        logic [4:0] s;
        int lat;
        acc(sp, 1'b1, a, d, s, lat);
        `CHK("write select", es, s)
        `CHK("write latency", 2, lat)
        acc(sp, 1'b0, a, 8'h00, s, lat);
        `CHK("read data", d, acc_rdata)
    endtask
    task automatic t_ranges();
        logic [23:0] a [6] = '{24'h07FFFF, 24'h080000, 24'h17FFFF,
                               24'h180000, 24'h0000FF, 24'h000100};
        logic [4:0] e [6] = '{5'h01, 5'h02, 5'h04, 5'h00, 5'h08, 5'h00};
        logic [4:0] s;
        int lat;
        for (int i = 0; i < 6; i++) begin
            acc(i < 4 ? XMB_SPACE_MEM : XMB_SPACE_IO, 1'b0, a[i], 8'h00, s, lat);
            `CHK("range select", e[i], s)
        end
    endtask
    task automatic t_fetch_wait();
        logic [4:0] s;
        int lat;
        acc(XMB_SPACE_FETCH, 1'b0, 24'h000010, 8'h00, s, lat);
        `CHK("fetch flag", 5'h11, s)
        waits <= 4'h4;
        acc(XMB_SPACE_MEM, 1'b0, 24'h000010, 8'h00, s, lat);
        `CHK("stretched", 1'b1, lat >= 6)
        `CHK("slow read", 8'hA5, acc_rdata)
        waits <= 4'h0;
    endtask
    task automatic t_release();
        int n = 0;
        @(posedge mclk);
        bus_release_request_n <= 1'b0;
        ext_addr <= 24'h080100;
        ext_mem_n <= 1'b0;
        while (bus_release_grant_n !== 1'b0 && n < 20) begin
            @(posedge mclk);
            #1 n++;
        end
        `CHK("grant", 1'b0, bus_release_grant_n)
        `CHK("oe in grant", 6'h10, oe_all)
        `CHK("granted flag", 1'b1, bus_granted)
        `CHK("outside select", 1'b0, select_out_second)
        `CHK("core held off", 1'b0, acc_ready)
        @(posedge mclk);
        bus_release_request_n <= 1'b1;
        ext_mem_n <= 1'b1;
        repeat (6) @(posedge mclk);
        #1 `CHK("bus retaken", 6'h3F, oe_all)
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        t_reset();
        t_rw(XMB_SPACE_MEM, 24'h000010, 8'hA5, 5'h01);
        t_rw(XMB_SPACE_IO, 24'h000090, 8'h5A, 5'h08);
        t_ranges();
        t_fetch_wait();
        t_release();
        tally_and_finish();
    end
    initial begin
        repeat (5000) @(posedge mclk);
        num_errors++;
        tally_and_finish();
    end
endmodule // test_xmb_pins
`default_nettype wire
